// >>> verilog/spi_port_pkg.sv
// Purpose: Shared constants and types of the serial port
// Assumes: 32-bit APB, byte-wide registers in the low lanes
// Notes:   All offsets are byte addresses

package spi_port_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_MODE_CTRL   = 8'h00;
    localparam logic [7:0] OFS_SHIFT_DATA  = 8'h04;
    localparam logic [7:0] OFS_FORMAT_CTRL = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h10;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_CTRL_RESET  = 8'he0;
    localparam logic [7:0] FORMAT_RESET     = 8'h00;
    localparam logic [7:0] SHIFT_DATA_RESET = 8'h00;
    localparam logic [2:0] IRQ_RESET        = 3'h0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MC_MODE_LSB    = 5;
    localparam int MC_PCK_LSB     = 2;
    localparam int MC_ENABLE_BIT  = 1;
    localparam int MC_INCOMP_BIT  = 0;
    localparam int FC_SPARE_LSB   = 6;
    localparam int FC_POL_BIT     = 5;
    localparam int FC_EDGE_BIT    = 4;
    localparam int FC_ORDER_BIT   = 3;
    localparam int FC_SELECT_PIN_ENABLE_BIT    = 2;
    localparam int FC_WRITE_COLLISION_FLAG_BIT    = 1;
    localparam int FC_TRF_BIT     = 0;
    localparam int IRQ_TRF_BIT    = 0;
    localparam int IRQ_WRITE_COLLISION_FLAG_BIT   = 1;
    localparam int IRQ_INCOMP_BIT = 2;

    // ------------------------------------------------------------
    // Timing counts, in system clock cycles per half shift clock; index of the last shift clock edge
    // ------------------------------------------------------------
    localparam logic [5:0] HALF_DIV4  = 6'h02;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV64 = 6'h20;
    localparam logic [3:0] LAST_EDGE  = 4'hf;

    typedef enum logic [2:0] {
        MODE_DIV4     = 3'b000,
        MODE_DIV16    = 3'b001,
        MODE_DIV64    = 3'b010,
        MODE_SUB      = 3'b011,
        MODE_TIMER    = 3'b100,
        MODE_SLAVE    = 3'b101,
        MODE_TWO_WIRE = 3'b110,
        MODE_UNUSED   = 3'b111
    } port_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01
    } shift_state_t;

endpackage : spi_port_pkg

// >>> verilog/shift_rate_gen.sv
// Purpose: Half-period tick of the master shift clock
// Assumes: subsidiary clock is asynchronous, timer match is a pclk pulse
// Notes:   Counter restarts whenever run drops

`timescale 1ns/100ps

module shift_rate_gen (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [2:0] mode,
    input  wire logic       run,
    input  wire logic       subsidiary_clock,
    input  wire logic       timer_period_match,
    output logic            tick
);

    logic [5:0] cnt_r;
    logic       sub_s1_r;
    logic       sub_s2_r;
    logic       sub_s3_r;
    logic       sub_f_r;
    logic       tick_r;

    wire [5:0] half_sel = (mode == spi_port_pkg::MODE_DIV4)  ? spi_port_pkg::HALF_DIV4  :
                          (mode == spi_port_pkg::MODE_DIV16) ? spi_port_pkg::HALF_DIV16 :
                                                               spi_port_pkg::HALF_DIV64;
    wire       div_mode = (mode == spi_port_pkg::MODE_DIV4) || (mode == spi_port_pkg::MODE_DIV16) ||
                          (mode == spi_port_pkg::MODE_DIV64);
    wire       wrap     = (cnt_r == half_sel - 6'h01);
    wire       sub_agree = (sub_s2_r == sub_s3_r);
    // Both edges of the slow clock make half periods, so the output follows it
    wire       sub_edge = sub_agree && (sub_s3_r != sub_f_r);
    wire       tick_nxt = run && ((div_mode && wrap) ||
                                  (mode == spi_port_pkg::MODE_SUB && sub_edge) ||
                                  (mode == spi_port_pkg::MODE_TIMER && timer_period_match));
    wire [5:0] cnt_nxt  = (run && div_mode && !wrap) ? cnt_r + 6'h01 : 6'h00;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r    <= 6'h00;
            sub_s1_r <= 1'b0;
            sub_s2_r <= 1'b0;
            sub_s3_r <= 1'b0;
            sub_f_r  <= 1'b0;
            tick_r   <= 1'b0;
        end
        else
        begin
            cnt_r    <= cnt_nxt;
            sub_s1_r <= subsidiary_clock;
            sub_s2_r <= sub_s1_r;
            sub_s3_r <= sub_s2_r;
            sub_f_r  <= sub_agree ? sub_s3_r : sub_f_r;
            tick_r   <= tick_nxt;
        end
    end

    assign tick = tick_r;

endmodule : shift_rate_gen

// >>> verilog/spi_master_slave_port.sv
// Purpose: Four-line full-duplex serial port, master or slave, on APB
// Assumes: pins are synchronised here; APB answers after one wait state
// Notes:   Two-wire mode and the clock prescaler output are not built

`timescale 1ns/100ps

// Functional notes
// - Modes 000/001/010 are master with shift clock pclk/4, /16, /64.
// - Mode 011 master on subsidiary clock; 100 master at half timer match rate.
// - Mode 101 is slave; no own clock, shifts on the external clock.
// - Enable low floats data, clock and select, and holds the port idle.
// - Enabling keeps control register contents; nothing reloads.
// - Slave select rising mid-transfer aborts and sets the incomplete flag.
// - Select-pin enable high uses the select pin; low leaves it floating.
// - Only the master starts transfers and drives the shift clock.
// - Each clock shifts one bit out and one bit in together.
// - One data register holds transmit data before and receive data after.
// - A single select output addresses one slave in master mode.
// - After reset mode reads 111, other mode register bits zero.
// - Hardware sets transfer-complete at each end except an abort; only software clears it.
// - Data write during a transfer is ignored and sets write-collision.
// - Polarity 0 idles high, 1 idles low; edge bit picks capture edge.
// - Bit order 1 shifts MSB first, 0 LSB first.
module spi_master_slave_port (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe,
    input  wire logic        sdi,
    output logic             sdo,
    output logic             sdo_oe,
    input  wire logic        ssel_n_in,
    output logic             ssel_n_out,
    output logic             ssel_n_oe,
    input  wire logic        subsidiary_clock,
    input  wire logic        timer_period_match
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [2:0]  mode_r;
    logic [2:0]  pck_r;
    logic        enable_r;
    logic        incomp_r;
    logic [7:0]  data_r;
    logic [1:0]  spare_r;
    logic        pol_r;
    logic        edge_r;
    logic        order_r;
    logic        select_pin_enable_r;
    logic        write_collision_flag_r;
    logic        trf_r;
    logic [2:0]  irq_status_r;
    logic [2:0]  irq_mask_r;
    logic        irq_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    spi_port_pkg::shift_state_t state_r;
    logic [3:0]  edge_cnt_r;
    logic        rx_bit_r;
    logic        sck_r;
    logic        sck_oe_r;
    logic        sdo_r;
    logic        sdo_oe_r;
    logic        ssel_n_r;
    logic        ssel_oe_r;
    logic        sck_f_d_r;
    logic        rate_tick;
    wire  [2:0]  pin_f;

    // ------------------------------------------------------------
    // Pin synchronisers: three stages, level taken once stages agree
    // ------------------------------------------------------------
    wire [2:0] pin_raw = {ssel_n_in, sck_in, sdi};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_sync
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic f_r;
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    s1_r <= 1'b1;
                    s2_r <= 1'b1;
                    s3_r <= 1'b1;
                    f_r  <= 1'b1;
                end
                else
                begin
                    s1_r <= pin_raw[gi];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    f_r  <= (s2_r == s3_r) ? s3_r : f_r;
                end
            end
            assign pin_f[gi] = f_r;
        end
    endgenerate

    wire sdi_f  = pin_f[0];
    wire sck_f  = pin_f[1];
    wire ssel_f = pin_f[2];

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire access    = psel && penable && pready_r;
    wire wr        = access && pwrite;
    wire rd        = access && !pwrite;
    wire hit_mode  = (paddr == spi_port_pkg::OFS_MODE_CTRL);
    wire hit_data  = (paddr == spi_port_pkg::OFS_SHIFT_DATA);
    wire hit_fmt   = (paddr == spi_port_pkg::OFS_FORMAT_CTRL);
    wire hit_stat  = (paddr == spi_port_pkg::OFS_IRQ_STATUS);
    wire hit_mask  = (paddr == spi_port_pkg::OFS_IRQ_MASK);
    wire mapped    = hit_mode || hit_data || hit_fmt || hit_stat || hit_mask;
    wire wr_mode   = wr && hit_mode;
    wire wr_data   = wr && hit_data;
    wire wr_fmt    = wr && hit_fmt;
    wire rd_stat   = rd && hit_stat;

    wire [7:0] mode_rd = {mode_r, pck_r, enable_r, incomp_r};
    wire [7:0] fmt_rd  = {spare_r, pol_r, edge_r, order_r, select_pin_enable_r, write_collision_flag_r, trf_r};
    wire [7:0] rd_byte = hit_mode ? mode_rd :
                         hit_data ? data_r :
                         hit_fmt  ? fmt_rd :
                         hit_stat ? {5'h00, irq_status_r} :
                         hit_mask ? {5'h00, irq_mask_r} : 8'h00;

    // ------------------------------------------------------------
    // Role and transfer decode
    // ------------------------------------------------------------
    // Two-wire and unused codes leave the port fully idle
    wire is_master = enable_r && (mode_r <= spi_port_pkg::MODE_TIMER);
    wire is_slave  = enable_r && (mode_r == spi_port_pkg::MODE_SLAVE);
    wire busy      = (state_r == spi_port_pkg::ST_SHIFT);
    wire selected  = !select_pin_enable_r || !ssel_f;
    wire slave_edge = (sck_f != sck_f_d_r);
    // Slave moves only on edges of the external clock
    wire step      = is_master ? (busy && rate_tick) : (is_slave && selected && slave_edge);
    wire leading   = !edge_cnt_r[0];
    wire last      = step && (edge_cnt_r == spi_port_pkg::LAST_EDGE);
    wire capture   = step && (leading == edge_r);
    // Launch edge is the opposite one; late-capture mode shifts on the last capture
    wire shift_en  = step && ((edge_r && !leading) ||
                              (!edge_r && leading && (edge_cnt_r != 4'h0)) ||
                              (!edge_r && last));
    wire in_bit    = (!edge_r && last) ? sdi_f : rx_bit_r;
    wire abort     = is_slave && busy && select_pin_enable_r && ssel_f;
    wire collide   = wr_data && busy;
    wire start_m   = wr_data && !busy && is_master;
    wire done      = last && !abort;

    wire [7:0] data_shifted = order_r ? {data_r[6:0], in_bit} : {in_bit, data_r[7:1]};
    wire [7:0] data_nxt = (wr_data && !busy) ? pwdata[7:0] :
                          shift_en ? data_shifted : data_r;

    wire stop      = abort || last || !(is_master || is_slave);
    wire go        = start_m || (is_slave && step && !busy);
    spi_port_pkg::shift_state_t state_nxt;
    assign state_nxt = stop ? spi_port_pkg::ST_IDLE :
                       go   ? spi_port_pkg::ST_SHIFT : state_r;
    wire [3:0] cnt_nxt = (stop || start_m) ? 4'h0 :
                         step ? edge_cnt_r + 4'h1 : edge_cnt_r;
    wire       busy_nxt = (state_nxt == spi_port_pkg::ST_SHIFT);
    // Idle level: polarity 0 idles high
    wire sck_nxt   = (is_master && busy && !last) ? (sck_r ^ rate_tick) : !pol_r;

    // ------------------------------------------------------------
    // Flags: hardware set wins over a software clear
    // ------------------------------------------------------------
    wire trf_nxt    = done || (trf_r && !(wr_fmt && !pwdata[spi_port_pkg::FC_TRF_BIT]));
    wire write_collision_flag_nxt   = collide || (write_collision_flag_r && !(wr_fmt && !pwdata[spi_port_pkg::FC_WRITE_COLLISION_FLAG_BIT]));
    wire incomp_nxt = abort || (incomp_r && !(wr_mode && !pwdata[spi_port_pkg::MC_INCOMP_BIT]));
    wire [2:0] events = {abort, collide, done};
    wire [2:0] irq_status_nxt = events | (irq_status_r & ~{3{rd_stat}});
    wire [2:0] irq_mask_nxt   = (wr && hit_mask) ? pwdata[2:0] : irq_mask_r;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Enable toggling never touches the other fields
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {mode_r, pck_r, enable_r} <= spi_port_pkg::MODE_CTRL_RESET[7:1];
            incomp_r <= spi_port_pkg::MODE_CTRL_RESET[0];
            {spare_r, pol_r, edge_r, order_r, select_pin_enable_r} <= spi_port_pkg::FORMAT_RESET[7:2];
            write_collision_flag_r   <= spi_port_pkg::FORMAT_RESET[1];
            trf_r    <= spi_port_pkg::FORMAT_RESET[0];
        end
        else
        begin
            if (wr_mode)
            begin
                {mode_r, pck_r, enable_r} <= pwdata[7:1];
            end
            if (wr_fmt)
            begin
                {spare_r, pol_r, edge_r, order_r, select_pin_enable_r} <= pwdata[7:2];
            end
            incomp_r <= incomp_nxt;
            write_collision_flag_r   <= write_collision_flag_nxt;
            trf_r    <= trf_nxt;
        end
    end

    // ------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_r     <= spi_port_pkg::SHIFT_DATA_RESET;
            state_r    <= spi_port_pkg::ST_IDLE;
            edge_cnt_r <= 4'h0;
            rx_bit_r   <= 1'b0;
            sck_f_d_r  <= 1'b1;
        end
        else
        begin
            data_r     <= data_nxt;
            state_r    <= state_nxt;
            edge_cnt_r <= cnt_nxt;
            rx_bit_r   <= capture ? sdi_f : rx_bit_r;
            sck_f_d_r  <= sck_f;
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sck_r     <= 1'b1;
            sck_oe_r  <= 1'b0;
            sdo_r     <= 1'b0;
            sdo_oe_r  <= 1'b0;
            ssel_n_r  <= 1'b1;
            ssel_oe_r <= 1'b0;
        end
        else
        begin
            sck_r     <= sck_nxt;
            sck_oe_r  <= is_master;
            sdo_r     <= order_r ? data_nxt[7] : data_nxt[0];
            sdo_oe_r  <= is_master || (is_slave && selected);
            ssel_n_r  <= !(is_master && busy_nxt);
            ssel_oe_r <= is_master && select_pin_enable_r;
        end
    end

    // ------------------------------------------------------------
    // APB answer and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r     <= 1'b0;
            pslverr_r    <= 1'b0;
            prdata_r     <= 32'h0000_0000;
            irq_status_r <= spi_port_pkg::IRQ_RESET;
            irq_mask_r   <= spi_port_pkg::IRQ_RESET;
            irq_r        <= 1'b0;
        end
        else
        begin
            pready_r     <= psel && penable && !pready_r;
            pslverr_r    <= psel && penable && !pready_r && !mapped;
            prdata_r     <= (psel && penable && !pready_r && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            irq_status_r <= irq_status_nxt;
            irq_mask_r   <= irq_mask_nxt;
            irq_r        <= |(irq_status_nxt & irq_mask_nxt);
        end
    end

    shift_rate_gen u_rate (
        .pclk               (pclk),
        .presetn            (presetn),
        .mode               (mode_r),
        .run                (is_master && busy),
        .subsidiary_clock   (subsidiary_clock),
        .timer_period_match (timer_period_match),
        .tick               (rate_tick)
    );

    assign prdata     = prdata_r;
    assign pready     = pready_r;
    assign pslverr    = pslverr_r;
    assign irq        = irq_r;
    assign sck_out    = sck_r;
    assign sck_oe     = sck_oe_r;
    assign sdo        = sdo_r;
    assign sdo_oe     = sdo_oe_r;
    assign ssel_n_out = ssel_n_r;
    assign ssel_n_oe  = ssel_oe_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A shift in the same cycle may still move the register
    sequence s_busy_write;
        wr_data && busy && !shift_en;
    endsequence

    sequence s_data_kept;
        write_collision_flag_r && $stable(data_r);
    endsequence

    property p_div4_rate;
        rate_tick && is_master && busy && mode_r == spi_port_pkg::MODE_DIV4 && !last
            |=> !rate_tick ##1 (rate_tick || !busy);
    endproperty
    a_div4_rate: assert property (p_div4_rate) else $error("div4 half period wrong");

    property p_timer_rate;
        timer_period_match && is_master && busy && mode_r == spi_port_pkg::MODE_TIMER
            |=> rate_tick;
    endproperty
    a_timer_rate: assert property (p_timer_rate) else $error("timer tick missing");

    property p_slave_no_clock;
        is_slave |=> !sck_oe;
    endproperty
    a_slave_no_clock: assert property (p_slave_no_clock) else $error("slave drives clock");

    property p_disabled_float;
        !enable_r [*2] |-> !sck_oe && !sdo_oe && !ssel_n_oe && !busy;
    endproperty
    a_disabled_float: assert property (p_disabled_float) else $error("pins driven while off");

    property p_abort;
        abort |=> incomp_r && !busy && irq_status_r[spi_port_pkg::IRQ_INCOMP_BIT];
    endproperty
    a_abort: assert property (p_abort) else $error("abort not flagged");

    property p_select_pin_enable_float;
        !select_pin_enable_r |=> !ssel_n_oe;
    endproperty
    a_select_pin_enable_float: assert property (p_select_pin_enable_float) else $error("select driven when off");

    property p_trf_set;
        done |=> trf_r && !busy;
    endproperty
    a_trf_set: assert property (p_trf_set) else $error("complete flag not set");

    property p_collision;
        s_busy_write |=> s_data_kept;
    endproperty
    a_collision: assert property (p_collision) else $error("collision write not ignored");

    property p_idle_level;
        is_master && !busy && $stable(pol_r) |=> sck_out == !$past(pol_r);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle clock level wrong");

    property p_edge_count;
        step && !stop |=> edge_cnt_r == $past(edge_cnt_r) + 4'h1;
    endproperty
    a_edge_count: assert property (p_edge_count) else $error("edge count slipped");

endmodule : spi_master_slave_port

// >>> tb/spi_peer_model.sv
// Purpose: External serial peripheral at the far side of the port
// Assumes: clock idles low, capture on rising edge, MSB first
// Notes:   No pull on the data line, so it inverts on deselect

`timescale 1ns/100ps

module spi_peer_model (
    input  wire logic       sck,
    input  wire logic       ssel_n,
    input  wire logic       sdo,
    input  wire logic [7:0] tx_byte,
    output logic      [7:0] rx_byte,
    output logic            sdi
);
    logic [7:0] tx_r;

    initial
    begin
        sdi = 1'b0;
        rx_byte = 8'h00;
        tx_r = 8'h00;
    end

    // First bit must stand before the first capture edge
    always @(negedge ssel_n)
    begin
        tx_r = tx_byte;
        sdi = tx_byte[7];
    end

    always @(posedge sck)
        if (ssel_n == 1'b0)
            rx_byte = {rx_byte[6:0], sdo};

    always @(negedge sck)
        if (ssel_n == 1'b0)
        begin
            tx_r = {tx_r[6:0], 1'b0};
            sdi = tx_r[7];
        end

    // Released line must not keep the last bit
    always @(posedge ssel_n)
        sdi = ~sdi;
endmodule : spi_peer_model

// >>> tb/spi_master_slave_port_bench.sv
// Purpose: Self-checking bench of the serial port over APB
// Assumes: peer model as the selected slave in master modes
// Notes:   Subsidiary clock tied low; timer match pulses every 8 cycles

`timescale 1ns/100ps

module spi_master_slave_port_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic        sck_out, sck_oe, sdo, sdo_oe, ssel_n_out, ssel_n_oe, sdi;
    logic        m_sck, m_ss_n, sck_w, ssel_n_w, rerr;
    logic [7:0]  paddr, peer_tx, peer_rx;
    logic [31:0] pwdata, prdata, rdat;
    int          error_cnt, n_compared;
    logic [2:0]  tcnt;

    assign sck_w    = sck_oe ? sck_out : m_sck;
    assign ssel_n_w = ssel_n_oe ? ssel_n_out : m_ss_n;

    spi_master_slave_port spi_master_slave_port_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .sck_in(sck_w), .sck_out(sck_out),
        .sck_oe(sck_oe), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .ssel_n_in(ssel_n_w),
        .ssel_n_out(ssel_n_out), .ssel_n_oe(ssel_n_oe), .subsidiary_clock(1'b0),
        .timer_period_match(tcnt == 3'h7));

    spi_peer_model spi_peer_model_i (.sck(sck_w), .ssel_n(ssel_n_w), .sdo(sdo), .tx_byte(peer_tx),
        .rx_byte(peer_rx), .sdi(sdi));

    initial pclk = 1'b0;
    always #2 pclk = ~pclk;
    always @(posedge pclk) tcnt <= tcnt + 3'h1;

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 64);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 64)
            error_cnt++;
    endtask : apb

    // Polls the complete flag; a hang shows as a flag mismatch
    task automatic wait_trf();
        int n;
        n = 0;
        do
        begin
            apb(1'b0, spi_port_pkg::OFS_FORMAT_CTRL, 8'h00);
            n++;
        end
        while (rdat[0] !== 1'b1 && n < 100);
        if (rdat[0] !== 1'b1)
            error_cnt++;
    endtask : wait_trf

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        {presetn, psel, penable, pwrite, m_sck} = 5'h00;
        {paddr, pwdata, rdat, rerr, tcnt} = '0;
        m_ss_n = 1'b1;
        peer_tx = 8'hc1;
        error_cnt = 0;
        n_compared = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, spi_port_pkg::OFS_MODE_CTRL, 8'h00);
        check(rdat[7:0], 8'he0);
        apb(1'b0, 8'h20, 8'h00);
        check(8'(rerr), 8'h01);
        apb(1'b1, spi_port_pkg::OFS_FORMAT_CTRL, 8'h3c);
        apb(1'b1, spi_port_pkg::OFS_MODE_CTRL, 8'h20);
        check({5'h00, sck_oe, sdo_oe, ssel_n_oe}, 8'h00);
        apb(1'b1, spi_port_pkg::OFS_MODE_CTRL, 8'h22);
        apb(1'b0, spi_port_pkg::OFS_FORMAT_CTRL, 8'h00);
        check(rdat[7:0], 8'h3c);
        check({6'h00, sck_out, ssel_n_oe}, 8'h01);
        apb(1'b1, spi_port_pkg::OFS_IRQ_MASK, 8'h07);
        // Second write lands mid-transfer and must be dropped
        apb(1'b1, spi_port_pkg::OFS_SHIFT_DATA, 8'ha5);
        apb(1'b1, spi_port_pkg::OFS_SHIFT_DATA, 8'h00);
        wait_trf();
        check(rdat[7:0], 8'h3f);
        check(8'(irq), 8'h01);
        apb(1'b0, spi_port_pkg::OFS_SHIFT_DATA, 8'h00);
        check(rdat[7:0], 8'hc1);
        check(peer_rx, 8'ha5);
        apb(1'b0, spi_port_pkg::OFS_IRQ_STATUS, 8'h00);
        check(rdat[7:0], 8'h03);
        apb(1'b1, spi_port_pkg::OFS_IRQ_MASK, 8'h04);
        apb(1'b1, spi_port_pkg::OFS_FORMAT_CTRL, 8'h34);
        apb(1'b0, spi_port_pkg::OFS_FORMAT_CTRL, 8'h00);
        check(rdat[7:0], 8'h34);
        apb(1'b1, spi_port_pkg::OFS_SHIFT_DATA, 8'h80);
        wait_trf();
        check(8'(irq), 8'h00);
        apb(1'b0, spi_port_pkg::OFS_SHIFT_DATA, 8'h00);
        check(rdat[7:0], 8'h83);
        check(peer_rx, 8'h01);
        apb(1'b1, spi_port_pkg::OFS_FORMAT_CTRL, 8'h34);
        apb(1'b1, spi_port_pkg::OFS_MODE_CTRL, 8'h02);
        apb(1'b1, spi_port_pkg::OFS_SHIFT_DATA, 8'h12);
        wait_trf();
        check(peer_rx, 8'h48);
        apb(1'b1, spi_port_pkg::OFS_FORMAT_CTRL, 8'h34);
        apb(1'b1, spi_port_pkg::OFS_MODE_CTRL, 8'h82);
        apb(1'b1, spi_port_pkg::OFS_SHIFT_DATA, 8'h0f);
        wait_trf();
        check(peer_rx, 8'hf0);
        apb(1'b1, spi_port_pkg::OFS_MODE_CTRL, 8'ha2);
        m_ss_n <= 1'b0;
        repeat (8) @(posedge pclk);
        check({6'h00, sck_oe, sdo_oe}, 8'h01);
        repeat (3)
        begin
            m_sck <= ~m_sck;
            repeat (8) @(posedge pclk);
        end
        m_ss_n <= 1'b1;
        repeat (12) @(posedge pclk);
        apb(1'b0, spi_port_pkg::OFS_MODE_CTRL, 8'h00);
        check(rdat[7:0], 8'ha3);
        check(8'(irq), 8'h01);
        print_verdict();
    end

    initial
    begin
        #20000;
        error_cnt++;
        print_verdict();
    end
endmodule : spi_master_slave_port_bench
